// >>> rtl/psram_ddr_fabric_port.sv
`timescale 1ns/1ns
`default_nettype none

module psram_ddr_fabric_port (
  input wire logic mclk,
  input wire logic rst,
  input wire logic quadrature_clock,
  input wire logic read_calibration_clock,
  input wire logic reset_n,
  input wire logic select_n,
  input wire logic mem_clock_true_rise,
  input wire logic mem_clock_true_fall,
  input wire logic mem_clock_comp_rise,
  input wire logic mem_clock_comp_fall,
  input wire logic [1:0] strobe_tx_rise,
  input wire logic [1:0] strobe_tx_fall,
  input wire logic [1:0] strobe_drive_enable,
  input wire logic [15:0] data_tx_rise,
  input wire logic [15:0] data_tx_fall,
  input wire logic [15:0] data_drive_enable,
  output logic [1:0] strobe_rx_rise,
  output logic [1:0] strobe_rx_fall,
  output logic [15:0] data_rx_rise,
  output logic [15:0] data_rx_fall,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic mem_reset_n,
  output logic mem_select_n,
  output logic mem_clock_true,
  output logic mem_clock_comp,
  output logic [15:0] mem_data_out,
  output logic [15:0] mem_data_oe,
  input wire logic [15:0] mem_data_in,
  output logic [1:0] mem_strobe_out,
  output logic [1:0] mem_strobe_oe,
  input wire logic [1:0] mem_strobe_in
);

  // transmit side: rising-edge register on mclk, falling half held a half cycle
  typedef struct packed {
    mem_port_pkg::tx_word_type word;
  } tx_state_type;

  tx_state_type tx_reg;
  tx_state_type tx_next;
  logic [1:0] clock_fall_reg;
  logic [15:0] data_fall_reg;
  logic [1:0] strobe_fall_reg;

  always_comb begin
    tx_next.word.reset_n = reset_n;
    tx_next.word.select_n = select_n;
    tx_next.word.clock_true_rise = mem_clock_true_rise;
    tx_next.word.clock_true_fall = mem_clock_true_fall;
    tx_next.word.clock_comp_rise = mem_clock_comp_rise;
    tx_next.word.clock_comp_fall = mem_clock_comp_fall;
    tx_next.word.strobe_tx_rise = strobe_tx_rise;
    tx_next.word.strobe_tx_fall = strobe_tx_fall;
    tx_next.word.strobe_drive_enable = strobe_drive_enable;
    tx_next.word.data_tx_rise = data_tx_rise;
    tx_next.word.data_tx_fall = data_tx_fall;
    tx_next.word.data_drive_enable = data_drive_enable;
  end

  // reset leaves the memory held in reset, deselected, pads released
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_reg <= '0;
      tx_reg.word.select_n <= 1'b1;
    end else begin
      tx_reg <= tx_next;
    end
  end

  // the fall halves move on the falling edge of the controller clock
  always_ff @(negedge mclk or posedge rst) begin
    if (rst) begin
      clock_fall_reg <= mem_port_pkg::STROBE_ZERO;
      data_fall_reg <= mem_port_pkg::DATA_ZERO;
      strobe_fall_reg <= mem_port_pkg::STROBE_ZERO;
    end else begin
      clock_fall_reg <= {tx_reg.word.clock_true_fall, tx_reg.word.clock_comp_fall};
      data_fall_reg <= tx_reg.word.data_tx_fall;
      strobe_fall_reg <= tx_reg.word.strobe_tx_fall;
    end
  end

  // one double-edge output cell per data pad; the lanes are independent so
  // each can sit beside its own pad
  wire logic [15:0] data_pad_mux;
  for (genvar lane = 0; lane < mem_port_pkg::DATA_WIDTH; lane++) begin : g_data_pad
    assign data_pad_mux[lane] = mclk ? tx_reg.word.data_tx_rise[lane] : data_fall_reg[lane];
  end

  // output mux: rise half while mclk high, fall half while low (ddr output)
  always_comb begin
    mem_reset_n = tx_reg.word.reset_n;
    mem_select_n = tx_reg.word.select_n;
    mem_data_oe = tx_reg.word.data_drive_enable;
    mem_strobe_oe = tx_reg.word.strobe_drive_enable;
    mem_data_out = data_pad_mux;
    if (mclk) begin
      mem_clock_true = tx_reg.word.clock_true_rise;
      mem_clock_comp = tx_reg.word.clock_comp_rise;
      mem_strobe_out = tx_reg.word.strobe_tx_rise;
    end else begin
      mem_clock_true = clock_fall_reg[1];
      mem_clock_comp = clock_fall_reg[0];
      mem_strobe_out = strobe_fall_reg;
    end
  end

  // receive side on the calibration clock
  // rise half captured on rising edge, fall half on falling, then paired
  typedef struct packed {
    mem_port_pkg::read_beat_type beat;
    logic toggle;
  } rx_state_type;

  // the calibration domain leaves reset on its own edge: a release that lands
  // next to a capture edge could otherwise split one beat across two states
  logic [1:0] cal_rst_sync_reg;
  logic cal_rst;
  always_ff @(posedge read_calibration_clock or posedge rst) begin
    if (rst) begin
      cal_rst_sync_reg <= 2'h3;
    end else begin
      cal_rst_sync_reg <= {cal_rst_sync_reg[0], 1'b0};
    end
  end
  assign cal_rst = cal_rst_sync_reg[1];

  logic [15:0] cal_data_fall_reg;
  logic [1:0] cal_strobe_fall_reg;
  logic [15:0] cal_data_rise_reg;
  logic [1:0] cal_strobe_rise_reg;
  rx_state_type rx_reg;
  rx_state_type rx_next;

  always_ff @(negedge read_calibration_clock or posedge cal_rst) begin
    if (cal_rst) begin
      cal_data_fall_reg <= mem_port_pkg::DATA_ZERO;
      cal_strobe_fall_reg <= mem_port_pkg::STROBE_ZERO;
    end else begin
      cal_data_fall_reg <= mem_data_in;
      cal_strobe_fall_reg <= mem_strobe_in;
    end
  end

  always_ff @(posedge read_calibration_clock or posedge cal_rst) begin
    if (cal_rst) begin
      cal_data_rise_reg <= mem_port_pkg::DATA_ZERO;
      cal_strobe_rise_reg <= mem_port_pkg::STROBE_ZERO;
    end else begin
      cal_data_rise_reg <= mem_data_in;
      cal_strobe_rise_reg <= mem_strobe_in;
    end
  end

  // read window: selected with every pad released; registered first so one
  // clean level crosses instead of a wide comparison that can glitch
  logic read_window_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      read_window_reg <= 1'b0;
    end else begin
      read_window_reg <= !select_n && data_drive_enable == mem_port_pkg::DATA_ZERO
        && strobe_drive_enable == mem_port_pkg::STROBE_ZERO;
    end
  end

  // read window into the calibration domain, closed while in reset
  logic [1:0] select_cal_sync_reg;
  logic select_sync_cal;
  always_ff @(posedge read_calibration_clock or posedge cal_rst) begin
    if (cal_rst) begin
      select_cal_sync_reg <= 2'h3;
    end else begin
      select_cal_sync_reg <= {select_cal_sync_reg[0], !read_window_reg};
    end
  end
  assign select_sync_cal = select_cal_sync_reg[1];

  // ack toggle back: a new beat is only taken after the previous one landed,
  // trading throughput for a safe word crossing; sustained reads lose beats,
  // so the controller has to pace its bursts
  logic ack_toggle_reg;
  logic [1:0] ack_sync_reg;
  logic rx_fifo_ready_cal;
  always_ff @(posedge read_calibration_clock or posedge cal_rst) begin
    if (cal_rst) begin
      ack_sync_reg <= 2'h0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[0], ack_toggle_reg};
    end
  end
  assign rx_fifo_ready_cal = ack_sync_reg[1] == rx_reg.toggle;

  // a beat is taken only inside the read window, and each beat flips a
  // toggle; the beat word stays still until the toggle is acknowledged
  always_comb begin
    rx_next = rx_reg;
    if (select_sync_cal == 1'b0 && rx_fifo_ready_cal) begin
      rx_next.beat.data_rise = cal_data_rise_reg;
      rx_next.beat.data_fall = cal_data_fall_reg;
      rx_next.beat.strobe_rise = cal_strobe_rise_reg;
      rx_next.beat.strobe_fall = cal_strobe_fall_reg;
      rx_next.toggle = ~rx_reg.toggle;
    end
  end

  always_ff @(posedge read_calibration_clock or posedge cal_rst) begin
    if (cal_rst) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  // mclk side: sync toggle, load stable beat into the fifo
  logic [2:0] req_sync_reg;
  logic push_valid;
  logic fifo_in_ready;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_sync_reg <= 3'h0;
      ack_toggle_reg <= 1'b0;
    end else begin
      req_sync_reg <= {req_sync_reg[1:0], rx_reg.toggle};
      if (push_valid && fifo_in_ready) begin
        ack_toggle_reg <= ~ack_toggle_reg;
      end
    end
  end
  assign push_valid = req_sync_reg[2] != ack_toggle_reg;

  mem_port_pkg::read_beat_type fifo_out;
  logic fifo_out_valid;
  logic fifo_out_take;

  stream_fifo #(
    .WIDTH(mem_port_pkg::BEAT_WIDTH),
    .DEPTH(mem_port_pkg::FIFO_DEPTH)
  ) read_fifo (
    .clk(mclk),
    .rst(rst),
    .in_data(rx_reg.beat),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_take)
  );

  // registered output stage: rx_valid and the beat leave from flops and hold
  // until the controller takes them; a full fifo pauses capture, never overwrites
  assign fifo_out_take = fifo_out_valid && (!rx_valid || rx_ready);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_valid <= 1'b0;
      data_rx_rise <= mem_port_pkg::DATA_ZERO;
      data_rx_fall <= mem_port_pkg::DATA_ZERO;
      strobe_rx_rise <= mem_port_pkg::STROBE_ZERO;
      strobe_rx_fall <= mem_port_pkg::STROBE_ZERO;
    end else begin
      if (fifo_out_take) begin
        rx_valid <= 1'b1;
        data_rx_rise <= fifo_out.data_rise;
        data_rx_fall <= fifo_out.data_fall;
        strobe_rx_rise <= fifo_out.strobe_rise;
        strobe_rx_fall <= fifo_out.strobe_fall;
      end else if (rx_ready) begin
        rx_valid <= 1'b0;
      end
    end
  end

endmodule : psram_ddr_fabric_port

`default_nettype wire

// >>> rtl/mem_port_pkg.sv
package mem_port_pkg;

  localparam int DATA_WIDTH = 16;
  localparam int STROBE_WIDTH = 2;
  localparam int MEM_DENSITY_MBIT = 256;
  localparam int MEM_CLOCK_MAX_MHZ = 200;
  localparam int LINE_RATE_MAX_MBPS = 400;
  localparam int FIFO_DEPTH = 16;
  localparam int CLOCK_MHZ = 50;
  localparam int LINK_PERIOD_NS = 64;

  // one read beat: data and strobe, rising and falling halves
  typedef struct packed {
    logic [DATA_WIDTH-1:0] data_rise;
    logic [DATA_WIDTH-1:0] data_fall;
    logic [STROBE_WIDTH-1:0] strobe_rise;
    logic [STROBE_WIDTH-1:0] strobe_fall;
  } read_beat_type;

  localparam int BEAT_WIDTH = $bits(read_beat_type);

  // what the controller hands the port for one memory clock cycle
  typedef struct packed {
    logic reset_n;
    logic select_n;
    logic clock_true_rise;
    logic clock_true_fall;
    logic clock_comp_rise;
    logic clock_comp_fall;
    logic [STROBE_WIDTH-1:0] strobe_tx_rise;
    logic [STROBE_WIDTH-1:0] strobe_tx_fall;
    logic [STROBE_WIDTH-1:0] strobe_drive_enable;
    logic [DATA_WIDTH-1:0] data_tx_rise;
    logic [DATA_WIDTH-1:0] data_tx_fall;
    logic [DATA_WIDTH-1:0] data_drive_enable;
  } tx_word_type;

  localparam logic [DATA_WIDTH-1:0] DATA_ZERO = 16'h0000;
  localparam logic [STROBE_WIDTH-1:0] STROBE_ZERO = 2'h0;
  localparam logic [3:0] PTR_ZERO = 4'h0;

endpackage : mem_port_pkg

// >>> rtl/stream_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_type;

  fifo_state_type state_reg;
  fifo_state_type state_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = state_reg.count != (AW+1)'(DEPTH);
  assign out_valid = state_reg.count != '0;
  assign out_data = mem[state_reg.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
    end
    state_next.count = state_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[state_reg.wr_ptr] <= in_data;
    end
  end

endmodule : stream_fifo

`default_nettype wire

// >>> verif/port_props.sv
`timescale 1ns/1ns
`default_nettype none

module port_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic select_n,
  input wire logic mem_clock_true_rise,
  input wire logic mem_clock_comp_fall,
  input wire logic [1:0] strobe_tx_rise,
  input wire logic [1:0] strobe_drive_enable,
  input wire logic [15:0] data_tx_rise,
  input wire logic [15:0] data_tx_fall,
  input wire logic [15:0] data_drive_enable,
  input wire logic [15:0] data_rx_rise,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic mem_reset_n,
  input wire logic mem_select_n,
  input wire logic mem_clock_true,
  input wire logic mem_clock_comp,
  input wire logic [15:0] mem_data_out,
  input wire logic [15:0] mem_data_oe,
  input wire logic [1:0] mem_strobe_out,
  input wire logic [1:0] mem_strobe_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // sampling at negedge sees the high phase, at posedge the low phase of the pad mux
  AST_MEM_RESET: assert property (mem_reset_n == $past(reset_n)) else $error("reset pin lag");
  AST_MEM_SELECT: assert property (mem_select_n == $past(select_n)) else $error("select pin lag");
  AST_DATA_OE: assert property (mem_data_oe == $past(data_drive_enable)) else $error("data oe");
  AST_STROBE_OE: assert property (mem_strobe_oe == $past(strobe_drive_enable)) else $error("strobe oe");
  AST_DATA_RISE: assert property (@(negedge mclk) mem_data_out == $past(data_tx_rise)) else $error("rise");
  AST_DATA_FALL: assert property (mem_data_out == $past(data_tx_fall)) else $error("data fall half");
  AST_CLOCK_RISE: assert property (@(negedge mclk) mem_clock_true == $past(mem_clock_true_rise)) else $error("ck");
  AST_CLOCK_FALL: assert property (mem_clock_comp == $past(mem_clock_comp_fall)) else $error("clock comp");
  AST_STROBE_RISE: assert property (@(negedge mclk) mem_strobe_out == $past(strobe_tx_rise)) else $error("s");
  AST_RX_HOLD: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(data_rx_rise)) else $error("rx");
  cover property (rx_valid && rx_ready);
  cover property ((rx_valid && !rx_ready) [*4]);
  cover property (!mem_select_n && mem_data_oe == 16'h0000);
endmodule : port_props

bind psram_ddr_fabric_port port_props chk (.mclk, .rst, .reset_n, .select_n, .mem_clock_true_rise,
  .mem_clock_comp_fall, .strobe_tx_rise, .strobe_drive_enable, .data_tx_rise, .data_tx_fall, .data_drive_enable,
  .data_rx_rise, .rx_valid, .rx_ready, .mem_reset_n, .mem_select_n, .mem_clock_true, .mem_clock_comp,
  .mem_data_out, .mem_data_oe, .mem_strobe_out, .mem_strobe_oe);

`default_nettype wire

// >>> verif/mem_die_model.sv
`timescale 1ns/1ns
`default_nettype none

module mem_die_model (
  input wire logic cal_clk,
  input wire logic mem_select_n,
  input wire logic [15:0] mem_data_out,
  input wire logic [15:0] mem_data_oe,
  input wire logic [1:0] mem_strobe_out,
  input wire logic [1:0] mem_strobe_oe,
  output logic [15:0] mem_data_in,
  output logic [1:0] mem_strobe_in
);
  logic [14:0] count_reg = 15'h0000;
  logic [15:0] word_reg = 16'h0000;
  logic [1:0] strobe_reg = 2'h0;
  logic drive;
  assign drive = !mem_select_n && mem_data_oe == 16'h0000 && mem_strobe_oe == 2'h0;
  // rise words odd with strobe high, fall words even; released lines toggle so no stale value survives
  always @(cal_clk) begin
    word_reg <= drive ? {count_reg, !cal_clk} : ~word_reg;
    strobe_reg <= drive ? {2{!cal_clk}} : ~strobe_reg;
    if (drive && !cal_clk) count_reg <= count_reg + 15'h0001;
  end
  assign mem_data_in = (mem_data_oe & mem_data_out) | (~mem_data_oe & word_reg);
  assign mem_strobe_in = (mem_strobe_oe & mem_strobe_out) | (~mem_strobe_oe & strobe_reg);
endmodule : mem_die_model

`default_nettype wire

// >>> verif/psram_ddr_fabric_port_tb.sv
`timescale 1ns/1ns
`default_nettype none

module psram_ddr_fabric_port_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic quad_clk = 1'b0;
  logic cal_clk = 1'b0;
  logic rx_ready = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [1:0] stall = 2'h0;
  logic [15:0] lfsr = 16'h654F;
  logic [15:0] last_rise = 16'h0000;
  logic [59:0] bits;
  mem_port_pkg::tx_word_type w = mem_port_pkg::tx_word_type'(60'h400000000000000);
  mem_port_pkg::tx_word_type nw, e;
  mem_port_pkg::tx_word_type q[$];
  logic [1:0] srr, srf, mso, msoe, msi;
  logic [15:0] drr, drf, mdo, mdoe, mdi;
  logic rxv, mrn, msn, mct, mcc;
  int fail_count = 0;
  int n_checks = 0;
  int beats = 0;

  always #10 mclk = ~mclk;
  always @(mclk) quad_clk <= #5 mclk;
  initial begin
    #7;
    forever #32 cal_clk = ~cal_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  psram_ddr_fabric_port DUT (.mclk(mclk), .rst(rst), .quadrature_clock(quad_clk), .read_calibration_clock(cal_clk),
    .reset_n(w.reset_n), .select_n(w.select_n), .mem_clock_true_rise(w.clock_true_rise),
    .mem_clock_true_fall(w.clock_true_fall), .mem_clock_comp_rise(w.clock_comp_rise),
    .mem_clock_comp_fall(w.clock_comp_fall), .strobe_tx_rise(w.strobe_tx_rise), .strobe_tx_fall(w.strobe_tx_fall),
    .strobe_drive_enable(w.strobe_drive_enable), .data_tx_rise(w.data_tx_rise), .data_tx_fall(w.data_tx_fall),
    .data_drive_enable(w.data_drive_enable), .strobe_rx_rise(srr), .strobe_rx_fall(srf), .data_rx_rise(drr),
    .data_rx_fall(drf), .rx_valid(rxv), .rx_ready(rx_ready), .mem_reset_n(mrn), .mem_select_n(msn),
    .mem_clock_true(mct), .mem_clock_comp(mcc), .mem_data_out(mdo), .mem_data_oe(mdoe), .mem_data_in(mdi),
    .mem_strobe_out(mso), .mem_strobe_oe(msoe), .mem_strobe_in(msi));

  mem_die_model die (.cal_clk(cal_clk), .mem_select_n(msn), .mem_data_out(mdo), .mem_data_oe(mdoe),
    .mem_strobe_out(mso), .mem_strobe_oe(msoe), .mem_data_in(mdi), .mem_strobe_in(msi));

  // random word every cycle; reads force select low and both enables off
  always @(posedge mclk) begin
    if (!rst) begin
      for (int i = 0; i < 60; i++) begin
        lfsr = lfsr_next(lfsr);
        bits = {bits[58:0], lfsr[0]};
      end
      nw = mem_port_pkg::tx_word_type'(bits);
      if (mode == 2'h1) nw.select_n = 1'b1;
      if (mode == 2'h2) begin
        nw.reset_n = 1'b1;
        nw.select_n = 1'b0;
        nw.data_drive_enable = mem_port_pkg::DATA_ZERO;
        nw.strobe_drive_enable = mem_port_pkg::STROBE_ZERO;
      end
      w <= nw;
      q.push_back(nw);
      rx_ready <= stall == 2'h1 ? 1'b0 : (stall == 2'h2 || bits[0]);
    end
  end

  // waits past the driver's push so the entry taken is the one launched a cycle earlier
  always @(posedge mclk) begin
    #5;
    if (q.size() > 1) begin
      e = q.pop_front();
      check({mct, mcc, mso, mdo, mdoe, msoe, msn, mrn}, {e.clock_true_rise, e.clock_comp_rise, e.strobe_tx_rise, e.data_tx_rise, e.data_drive_enable, e.strobe_drive_enable, e.select_n, e.reset_n});
      @(negedge mclk);
      #5;
      check({mct, mcc, mso, mdo}, {e.clock_true_fall, e.clock_comp_fall, e.strobe_tx_fall, e.data_tx_fall});
    end
  end

  always @(posedge mclk) begin
    if (mode == 2'h2 && rxv === 1'b1 && rx_ready === 1'b1) begin
      beats++;
      check({srr, srf, drr[0], drf[0]}, {2'h3, 2'h0, 1'b1, 1'b0});
      check(drr > last_rise, 1);
      last_rise = drr;
    end
  end

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (400) @(posedge mclk);
    $display("test tx pads done");
    mode <= 2'h1;
    stall <= 2'h2;
    repeat (60) @(posedge mclk);
    mode <= 2'h2;
    stall <= 2'h0;
    repeat (300) @(posedge mclk);
    check(beats > 0, 1);
    stall <= 2'h1;
    repeat (400) @(posedge mclk);
    beats = 0;
    stall <= 2'h2;
    repeat (20) @(posedge mclk);
    check(beats >= mem_port_pkg::FIFO_DEPTH, 1);
    $display("test read and buffer done");
    tally_and_finish();
  end
endmodule : psram_ddr_fabric_port_tb

`default_nettype wire
